//--- rtl/ospt_defs.svh
// constants for the one-shot pulse timer: register offsets, bit positions,
// reset values, timing figures. assumes a 20 MHz ref_clk.
`ifndef OSPT_DEFS_SVH
`define OSPT_DEFS_SVH

// register byte offsets on the axi4-lite bus
`define OSPT_MODE_OFS     12'h000
`define OSPT_CCC_OFS      12'h004
`define OSPT_OUTCTL_OFS   12'h008
`define OSPT_PRESC_OFS    12'h00c
`define OSPT_CYCLE_OFS    12'h010
`define OSPT_DUTY_OFS     12'h014
`define OSPT_COUNT_OFS    12'h018
`define OSPT_STATUS_OFS   12'h01c

// mode control register fields
`define OSPT_MODE_LO_BIT  2
`define OSPT_MODE_HI_BIT  3
`define OSPT_OVF_BIT      0
// output control register fields
`define OSPT_OUTEN_BIT    0
`define OSPT_LVR_BIT      2
`define OSPT_LVS_BIT      3
`define OSPT_OSEN_BIT     5
`define OSPT_TRIG_BIT     6
// prescaler register fields
`define OSPT_PRS_LO_BIT   0
`define OSPT_ES0_BIT      4
`define OSPT_ES1_BIT      5

// reset values
`define OSPT_MODE_RST     8'h00
`define OSPT_OUTCTL_RST   8'h00
`define OSPT_PRESC_RST    8'h00
`define OSPT_CMP_RST      16'h0000
`define OSPT_CCC_RST      8'h00

// prescaler divide exponents, selected by prescaler bits 1:0
`define OSPT_DIV_SEL0     4'h0
`define OSPT_DIV_SEL1     4'h2
`define OSPT_DIV_SEL2     4'h8
`define OSPT_DIV_SEL3     4'h0

`define OSPT_BRESP_OKAY   2'b00
`define OSPT_BRESP_SLVERR 2'b10

`endif

//--- rtl/ospt_pkg.sv
// types shared by the one-shot pulse timer files.
// no constants here; figures live in ospt_defs.svh.
package ospt_pkg;
    // counter operating mode, two bits of the mode control register
    typedef enum logic [1:0] {
        OSPT_STOP,
        OSPT_FREE,
        OSPT_EDGE_CLR,
        OSPT_CYC_CLR
    } ospt_mode_e;

    // valid trigger edge selection
    typedef enum logic [1:0] {
        OSPT_EDGE_FALL,
        OSPT_EDGE_RISE,
        OSPT_EDGE_NONE,
        OSPT_EDGE_BOTH
    } ospt_edge_e;

    // compare match events of one count tick
    typedef struct packed {
        logic cycleMatch;
        logic dutyMatch;
        logic overflow;
    } ospt_match_s;
endpackage

//--- rtl/ospt_edge_det.sv
// valid edge detector for the trigger input pin.
// assumes the pin is synchronous to ref_clk; sampling follows the count tick.
`timescale 1ns/1ps
`include "ospt_defs.svh"

module ospt_edge_det
    import ospt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire ospt_edge_e edgeSel,
    input  wire logic       pinIn,
    output logic            validEdge
);
    logic lastLevel_reg;  // last level sampled on a tick
    logic lastLevel_next;
    logic validEdge_reg;  // one tick-pulse per detected edge
    logic validEdge_next;

    assign validEdge = validEdge_reg;

    // edge compare, only while the counter runs
    always_comb begin
        lastLevel_next = lastLevel_reg;
        // held until the next tick takes it; with a slow prescaler or a
        // read pause the one-cycle pulse would fall between ticks
        validEdge_next = tick ? 1'b0 : validEdge_reg;
        if (!enable)
            validEdge_next = 1'b0;
        if (tick) begin
            lastLevel_next = pinIn;
            if (enable) begin
                unique case (edgeSel)
                    OSPT_EDGE_RISE: validEdge_next = pinIn & ~lastLevel_reg;
                    OSPT_EDGE_FALL: validEdge_next = ~pinIn & lastLevel_reg;
                    OSPT_EDGE_BOTH: validEdge_next = pinIn ^ lastLevel_reg;
                    OSPT_EDGE_NONE: validEdge_next = 1'b0;
                endcase
            end
        end
    end

    // sampled state; a stopped timer sees no edges
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            lastLevel_reg <= 1'b0;
            validEdge_reg <= 1'b0;
        end else begin
            lastLevel_reg <= lastLevel_next;
            validEdge_reg <= validEdge_next;
        end
    end
endmodule

//--- rtl/ospt_timer.sv
// one-shot pulse timer: 16-bit counter, two compares, axi4-lite registers.
// assumes trigger pin synchronous to ref_clk and a single axi master.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "ospt_defs.svh"

module ospt_timer
    import ospt_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pins
    input  wire logic        trigPin,
    output logic             timerOut,
    output logic             cycleMatchIrq,
    output logic             dutyMatchIrq
);
    // register state
    logic [7:0]  mode_reg, mode_next;      // mode control
    logic [7:0]  ccc_reg, ccc_next;        // capture/compare control
    logic [7:0]  outCtl_reg, outCtl_next;  // output control (no trigger)
    logic [7:0]  presc_reg, presc_next;    // prescaler and edge select
    logic [15:0] cycle_reg, cycle_next;    // cycle compare
    logic [15:0] duty_reg, duty_next;      // duty compare
    logic [15:0] count_reg, count_next;    // counter value
    logic        out_reg, out_next;        // timer output level
    logic        pulse_reg, pulse_next;    // one-shot pulse in progress
    logic        armed_reg, armed_next;    // pulse window not yet done
    logic        trigPend_reg, trigPend_next; // trigger awaiting a tick
    logic        cycIrq_reg, cycIrq_next;
    logic        dutyIrq_reg, dutyIrq_next;
    logic [7:0]  presc_cnt_reg, presc_cnt_next; // count clock divider
    // bus state
    logic        awGot_reg, awGot_next;
    logic        wGot_reg, wGot_next;
    logic [11:0] awAddr_reg, awAddr_next;
    logic [31:0] wData_reg, wData_next;
    logic [3:0]  wStrb_reg, wStrb_next;
    logic        bValid_reg, bValid_next;
    logic [1:0]  bResp_reg, bResp_next;
    logic        rValid_reg, rValid_next;
    logic [31:0] rData_reg, rData_next;
    logic [1:0]  rResp_reg, rResp_next;
    logic        readHold_reg, readHold_next; // counter read in progress

    ospt_mode_e  opMode;
    ospt_match_s match;
    logic        running;
    logic        tick;
    logic        validEdge;
    logic [3:0]  divExp;
    logic        wrFire;
    logic        swTrig;

    // known register offset check, used by read and write decode
    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a == `OSPT_MODE_OFS) || (a == `OSPT_CCC_OFS) ||
                   (a == `OSPT_OUTCTL_OFS) || (a == `OSPT_PRESC_OFS) ||
                   (a == `OSPT_CYCLE_OFS) || (a == `OSPT_DUTY_OFS) ||
                   (a == `OSPT_COUNT_OFS) || (a == `OSPT_STATUS_OFS);
    endfunction

    assign opMode  = ospt_mode_e'(mode_reg[`OSPT_MODE_HI_BIT:`OSPT_MODE_LO_BIT]);
    assign running = (opMode != OSPT_STOP);
    assign wrFire  = awGot_reg & wGot_reg & ~bValid_reg;

    // prescaler exponent select
    always_comb begin
        unique case (presc_reg[1:0])
            2'd0: divExp = `OSPT_DIV_SEL0;
            2'd1: divExp = `OSPT_DIV_SEL1;
            2'd2: divExp = `OSPT_DIV_SEL2;
            2'd3: divExp = `OSPT_DIV_SEL3;
        endcase
    end

    // count tick: divider rolls over, paused during a counter read
    assign tick = running & ~readHold_reg &
                  ((presc_cnt_reg & ((8'h01 << divExp) - 8'h01)) == 8'h00);

    // match events on the current count value
    assign match.cycleMatch = tick & (count_reg == cycle_reg);
    assign match.dutyMatch  = tick & (count_reg == duty_reg);
    // wrap from ffff; zero compare then fires on 0000 to 0001
    assign match.overflow   = tick & (count_reg == 16'hffff);

    // software trigger strobe from a write of the output control register
    assign swTrig = wrFire & (awAddr_reg == `OSPT_OUTCTL_OFS) & wStrb_reg[0] &
                    wData_reg[`OSPT_TRIG_BIT];

    ospt_edge_det uEdge (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .tick     (tick),
        .enable   (running),
        .edgeSel  (ospt_edge_e'(presc_reg[`OSPT_ES1_BIT:`OSPT_ES0_BIT])),
        .pinIn    (trigPin),
        .validEdge(validEdge)
    );

    // counter, output and match logic
    always_comb begin
        presc_cnt_next = running ? presc_cnt_reg + 8'h01 : 8'h00;
        count_next     = count_reg;
        out_next       = out_reg;
        pulse_next     = pulse_reg;
        armed_next     = armed_reg;
        trigPend_next  = trigPend_reg;
        cycIrq_next    = 1'b0;
        dutyIrq_next   = 1'b0;
        // one-shot allowed only outside cycle-clear mode
        if (swTrig && outCtl_reg[`OSPT_OSEN_BIT] && running &&
            opMode != OSPT_CYC_CLR) begin
            trigPend_next = 1'b1;
        end
        if (!running) begin
            count_next    = 16'h0000;
            out_next      = 1'b0;
            pulse_next    = 1'b0;
            armed_next    = 1'b0;
            trigPend_next = 1'b0;
        end else if (tick) begin
            // start skews by up to one tick
            if (trigPend_reg ||
                (validEdge && outCtl_reg[`OSPT_OSEN_BIT] &&
                 opMode != OSPT_CYC_CLR)) begin
                count_next    = 16'h0000;
                trigPend_next = 1'b0;
                armed_next    = 1'b1;
                out_next      = 1'b0;
            end else begin
                if (opMode == OSPT_CYC_CLR && match.cycleMatch)
                    count_next = 16'h0000;
                else if (opMode == OSPT_EDGE_CLR && validEdge)
                    count_next = 16'h0000;
                else
                    count_next = count_reg + 16'h0001;
                cycIrq_next  = match.cycleMatch;
                dutyIrq_next = match.dutyMatch;
                if (armed_reg && outCtl_reg[`OSPT_OUTEN_BIT]) begin
                    if (duty_reg < cycle_reg) begin
                        if (match.dutyMatch) begin
                            out_next   = 1'b1;
                            pulse_next = 1'b1;
                        end
                        if (match.cycleMatch && pulse_reg) begin
                            out_next   = 1'b0;
                            pulse_next = 1'b0;
                            armed_next = 1'b0;
                        end
                    end else begin
                        if (match.cycleMatch) begin
                            out_next   = 1'b1;
                            pulse_next = 1'b1;
                        end
                        if (match.dutyMatch && pulse_reg) begin
                            out_next   = 1'b0;
                            pulse_next = 1'b0;
                            armed_next = 1'b0;
                        end
                    end
                end
            end
        end
    end

    // axi write, read and register update
    always_comb begin
        awGot_next   = awGot_reg;
        wGot_next    = wGot_reg;
        awAddr_next  = awAddr_reg;
        wData_next   = wData_reg;
        wStrb_next   = wStrb_reg;
        bValid_next  = bValid_reg;
        bResp_next   = bResp_reg;
        rValid_next  = rValid_reg;
        rData_next   = rData_reg;
        rResp_next   = rResp_reg;
        readHold_next = 1'b0;
        mode_next    = mode_reg;
        ccc_next     = ccc_reg;
        outCtl_next  = outCtl_reg;
        presc_next   = presc_reg;
        cycle_next   = cycle_reg;
        duty_next    = duty_reg;
        // overflow flag is hardware set, set wins over software clear
        if (s_axi_awvalid && !awGot_reg) begin
            awGot_next  = 1'b1;
            awAddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !wGot_reg) begin
            wGot_next  = 1'b1;
            wData_next = s_axi_wdata;
            wStrb_next = s_axi_wstrb;
        end
        if (wrFire) begin
            awGot_next  = 1'b0;
            wGot_next   = 1'b0;
            bValid_next = 1'b1;
            bResp_next  = isMapped(awAddr_reg) ? `OSPT_BRESP_OKAY
                                               : `OSPT_BRESP_SLVERR;
            if (wStrb_reg[0]) begin
                unique case (awAddr_reg)
                    `OSPT_MODE_OFS:   mode_next   = wData_reg[7:0];
                    `OSPT_CCC_OFS:    ccc_next    = wData_reg[7:0];
                    // trigger, set and reset bits not stored
                    `OSPT_OUTCTL_OFS: outCtl_next = wData_reg[7:0] & 8'hb3;
                    `OSPT_PRESC_OFS:  presc_next  = wData_reg[7:0];
                    `OSPT_CYCLE_OFS:  cycle_next[7:0] = wData_reg[7:0];
                    `OSPT_DUTY_OFS:   duty_next[7:0]  = wData_reg[7:0];
                    default: ;
                endcase
            end
            if (wStrb_reg[1]) begin
                if (awAddr_reg == `OSPT_CYCLE_OFS)
                    cycle_next[15:8] = wData_reg[15:8];
                if (awAddr_reg == `OSPT_DUTY_OFS)
                    duty_next[15:8] = wData_reg[15:8];
            end
        end
        if (match.overflow)
            mode_next[`OSPT_OVF_BIT] = 1'b1;
        if (bValid_reg && s_axi_bready)
            bValid_next = 1'b0;
        // read: a count read pauses the counter for one cycle of hold
        if (s_axi_arvalid && !rValid_reg) begin
            rValid_next = 1'b1;
            rResp_next  = isMapped(s_axi_araddr) ? `OSPT_BRESP_OKAY
                                                 : `OSPT_BRESP_SLVERR;
            rData_next  = 32'h0000_0000;
            unique case (s_axi_araddr)
                `OSPT_MODE_OFS:   rData_next[7:0]  = mode_reg;
                `OSPT_CCC_OFS:    rData_next[7:0]  = ccc_reg;
                `OSPT_OUTCTL_OFS: rData_next[7:0]  = outCtl_reg;
                `OSPT_PRESC_OFS:  rData_next[7:0]  = presc_reg;
                `OSPT_CYCLE_OFS:  rData_next[15:0] = cycle_reg;
                `OSPT_DUTY_OFS:   rData_next[15:0] = duty_reg;
                `OSPT_COUNT_OFS: begin
                    rData_next[15:0] = count_reg;
                    readHold_next    = 1'b1;
                end
                `OSPT_STATUS_OFS: rData_next[2:0] =
                    {armed_reg, pulse_reg, out_reg};
                default: ;
            endcase
        end
        if (rValid_reg && s_axi_rready)
            rValid_next = 1'b0;
    end

    // registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            mode_reg <= `OSPT_MODE_RST;
            ccc_reg <= `OSPT_CCC_RST;
            outCtl_reg <= `OSPT_OUTCTL_RST;
            presc_reg <= `OSPT_PRESC_RST;
            cycle_reg <= `OSPT_CMP_RST;
            duty_reg <= `OSPT_CMP_RST;
            count_reg <= 16'h0000;
            out_reg <= 1'b0;
            pulse_reg <= 1'b0;
            armed_reg <= 1'b0;
            trigPend_reg <= 1'b0;
            cycIrq_reg <= 1'b0;
            dutyIrq_reg <= 1'b0;
            presc_cnt_reg <= 8'h00;
            awGot_reg <= 1'b0;
            wGot_reg <= 1'b0;
            awAddr_reg <= 12'h000;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg <= 2'b00;
            rValid_reg <= 1'b0;
            rData_reg <= 32'h0000_0000;
            rResp_reg <= 2'b00;
            readHold_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            ccc_reg <= ccc_next;
            outCtl_reg <= outCtl_next;
            presc_reg <= presc_next;
            cycle_reg <= cycle_next;
            duty_reg <= duty_next;
            count_reg <= count_next;
            out_reg <= out_next;
            pulse_reg <= pulse_next;
            armed_reg <= armed_next;
            trigPend_reg <= trigPend_next;
            cycIrq_reg <= cycIrq_next;
            dutyIrq_reg <= dutyIrq_next;
            presc_cnt_reg <= presc_cnt_next;
            awGot_reg <= awGot_next;
            wGot_reg <= wGot_next;
            awAddr_reg <= awAddr_next;
            wData_reg <= wData_next;
            wStrb_reg <= wStrb_next;
            bValid_reg <= bValid_next;
            bResp_reg <= bResp_next;
            rValid_reg <= rValid_next;
            rData_reg <= rData_next;
            rResp_reg <= rResp_next;
            readHold_reg <= readHold_next;
        end
    end

    // outputs straight from flops
    assign s_axi_awready = ~awGot_reg;
    assign s_axi_wready  = ~wGot_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = ~rValid_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rdata   = rData_reg;
    assign s_axi_rresp   = rResp_reg;
    assign timerOut      = out_reg;
    assign cycleMatchIrq = cycIrq_reg;
    assign dutyMatchIrq  = dutyIrq_reg;
endmodule

//--- tb/ospt_far_end.sv
// far side of the timer: trigger source on the pin, pulse width meter.
// assumes the pin is driven synchronous to ref_clk, as the timer expects.
`timescale 1ns/1ps
module ospt_far_end (
    input  wire logic ref_clk,
    input  wire logic timerOut,
    output logic      trigPin
);
    int pulses;  // completed pulses seen
    int width;   // length of the last pulse in cycles
    int run;     // length of the pulse in progress
    int stalls;  // waits for pulse end that ran out
    initial begin
        trigPin = 1'b0;
        stalls = 0;
        pulses = 0;
        width = 0;
        run = 0;
    end
    // pulse meter; counts edges at which the output is high
    always @(posedge ref_clk) begin
        if (timerOut === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            width <= run;
            pulses <= pulses + 1;
            run <= 0;
        end
    end
    // one edge on the pin; waits up to 400 cycles for a pulse to end, level held otherwise
    task automatic edge_to(input logic lvl);
        int i;
        for (i = 0; i < 400 && timerOut === 1'b1; i++) begin
            @(posedge ref_clk);
        end
        if (i == 400) stalls++;
        @(posedge ref_clk);
        trigPin <= lvl;
    endtask
endmodule

//--- tb/ospt_timer_chk.sv
// bus and pulse output checks on the timer ports.
// assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module ospt_timer_chk (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        timerOut,
    input wire logic        cycleMatchIrq,
    input wire logic        dutyMatchIrq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // answers stand until taken
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    // output moves only on the edge of a compare match pulse or one edge after it
    a_out_rise_match: assert property ($rose(timerOut) |->
        $past(cycleMatchIrq || dutyMatchIrq)
        || cycleMatchIrq || dutyMatchIrq) else $error("rise w/o match");
    a_out_fall_match: assert property ($fell(timerOut) |->
        $past(cycleMatchIrq || dutyMatchIrq)
        || cycleMatchIrq || dutyMatchIrq) else $error("fall w/o match");
    a_cyc_irq_pulse: assert property (cycleMatchIrq |=> !cycleMatchIrq)
        else $error("cycle match pulse too long");
    a_duty_irq_pulse: assert property (dutyMatchIrq |=> !dutyMatchIrq)
        else $error("duty match pulse too long");
endmodule
bind ospt_timer ospt_timer_chk chk (.ref_clk(ref_clk), .resetn(resetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .timerOut(timerOut),
    .cycleMatchIrq(cycleMatchIrq), .dutyMatchIrq(dutyMatchIrq));

//--- tb/one_shot_pulse_timer_test.sv
// register-level bench for the one-shot pulse timer, 20 MHz ref_clk.
// assumes prescaler divide 1, so one count tick per clock.
`timescale 1ns/1ps
`include "ospt_defs.svh"
`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin \
    miscompares++; $display("Error %s expected %0h seen %0h", nm, ex, sn); \
    end end
module one_shot_pulse_timer_test;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
    logic [31:0] wData = 32'h0;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
    logic        arValid = 1'b0, rReady = 1'b0;
    wire         awReady, wReady, bValid, arReady, rValid, trigPin, tOut;
    wire  [1:0]  bResp, rResp;
    wire  [31:0] rData;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] d, c1;  // read data, earlier count
    logic [1:0]  r;      // response code
    int n, k;
    logic [31:0] es [3] = '{32'h00, 32'h10, 32'h30};  // fall, rise, both
    logic        lv [3] = '{1'b0, 1'b1, 1'b0};       // edge target level
    always #25 ref_clk = ~ref_clk;
    ospt_timer uut (.ref_clk(ref_clk), .resetn(resetn),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .trigPin(trigPin),
        .timerOut(tOut), .cycleMatchIrq(), .dutyMatchIrq());
    ospt_far_end far (.ref_clk(ref_clk), .timerOut(tOut),
        .trigPin(trigPin));
    // verdict and end of run
    task automatic end_sim();
        miscompares += far.stalls;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one write; each channel released at the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        int i;
        @(posedge ref_clk);
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge ref_clk);
            if (awReady === 1'b1) awValid <= 1'b0;
            if (wReady === 1'b1) wValid <= 1'b0;
            if (bValid === 1'b1 && !awValid && !wValid) begin
                r = bResp;
                bReady <= 1'b0;
                break;
            end
        end
        if (i == 100) begin
            miscompares++;
            end_sim();
        end
    endtask
    // one read; data taken at the edge where rvalid is seen
    task automatic rd(input logic [11:0] a);
        int i;
        @(posedge ref_clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge ref_clk);
            if (arReady === 1'b1) arValid <= 1'b0;
            if (rValid === 1'b1 && !arValid) begin
                d = rData;
                r = rResp;
                rReady <= 1'b0;
                break;
            end
        end
        if (i == 100) begin
            miscompares++;
            end_sim();
        end
    endtask
    // bounded wait for a pulse after count n0, then its width
    task automatic pulse_is(input int n0, input int w);
        int i;
        for (i = 0; i < 600 && far.pulses == n0; i++) @(posedge ref_clk);
        if (i == 600) begin
            miscompares++;
            end_sim();
        end
        `CHK("pulse width", w, far.width)
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(`OSPT_MODE_OFS);
        `CHK("mode reset", 32'h0, d)
        rd(`OSPT_PRESC_OFS);
        `CHK("prescaler reset", 32'h0, d)
        rd(`OSPT_CYCLE_OFS);
        `CHK("cycle reset", 32'h0, d)
        rd(12'h100);
        `CHK("unmapped read", 34'h2_0000_0000, {r, d})
        wr(12'h100, 32'h5);
        `CHK("unmapped write", 2'b10, r)
        wr(`OSPT_OUTCTL_OFS, 32'h6d);
        rd(`OSPT_OUTCTL_OFS);
        `CHK("outctl readback", 32'h21, d)
        far.edge_to(1'b1);
        far.edge_to(1'b0);
        repeat (20) @(posedge ref_clk);
        rd(`OSPT_COUNT_OFS);
        `CHK("stopped count", 32'h0, d)
        `CHK("stopped pulses", 0, far.pulses)
        wr(`OSPT_CYCLE_OFS, 32'd40);
        wr(`OSPT_DUTY_OFS, 32'd10);
        wr(`OSPT_PRESC_OFS, 32'h10);
        wr(`OSPT_MODE_OFS, 32'h04);
        rd(`OSPT_COUNT_OFS);
        c1 = d;
        rd(`OSPT_COUNT_OFS);
        `CHK("count runs", 1'b1, d > c1)
        rd(`OSPT_DUTY_OFS);
        `CHK("duty after count read", 32'd10, d)
        n = far.pulses;
        wr(`OSPT_OUTCTL_OFS, 32'h61);
        pulse_is(n, 30);
        rd(`OSPT_OUTCTL_OFS);
        `CHK("trigger self-clear", 32'h21, d)
        c1 = d;
        rd(`OSPT_COUNT_OFS);
        c1 = d;
        rd(`OSPT_COUNT_OFS);
        `CHK("count after pulse", 1'b1, d !== c1)
        n = far.pulses;
        far.edge_to(1'b1);
        pulse_is(n, 30);
        wr(`OSPT_MODE_OFS, 32'h00);
        wr(`OSPT_DUTY_OFS, 32'd50);
        wr(`OSPT_CYCLE_OFS, 32'd20);
        wr(`OSPT_MODE_OFS, 32'h04);
        n = far.pulses;
        wr(`OSPT_OUTCTL_OFS, 32'h61);
        pulse_is(n, 30);
        // pin starts high: fall, rise, both in turn need no extra edges
        for (k = 0; k < 3; k++) begin
            wr(`OSPT_MODE_OFS, 32'h00);
            wr(`OSPT_PRESC_OFS, es[k]);
            wr(`OSPT_MODE_OFS, 32'h08);
            n = far.pulses;
            far.edge_to(lv[k]);
            pulse_is(n, 30);
        end
        wr(`OSPT_MODE_OFS, 32'h00);
        wr(`OSPT_PRESC_OFS, 32'h20);
        wr(`OSPT_MODE_OFS, 32'h08);
        n = far.pulses;
        far.edge_to(1'b1);
        repeat (200) @(posedge ref_clk);
        `CHK("no edge selected", n, far.pulses)
        wr(`OSPT_MODE_OFS, 32'h00);
        wr(`OSPT_MODE_OFS, 32'h0c);
        wr(`OSPT_OUTCTL_OFS, 32'h61);
        repeat (200) @(posedge ref_clk);
        `CHK("cycle-clear one-shot", n, far.pulses)
        end_sim();
    end
endmodule
